// >>> pkg/egpio_defines.vh
// Purpose: Offsets, widths and reset values of the controller pin banks.
// Assumes: Registers sit at their byte offsets on an 8-bit address port.
// Notes:   Lock registers are writable only by the embedded controller.
`ifndef EGPIO_DEFINES_VH
`define EGPIO_DEFINES_VH

`define EGPIO_AW               8
`define EGPIO_DW               16
`define EGPIO_B0_W             16
`define EGPIO_B1_W             8
`define EGPIO_B2_W             16
`define EGPIO_SYNC_STAGES      3

`define EGPIO_LOCK_B2          8'h90
`define EGPIO_LOCK_B1          8'h98
`define EGPIO_LOCK_B0          8'hA0
`define EGPIO_B0_OUT           8'hC6
`define EGPIO_B0_OEN           8'hC8
`define EGPIO_B0_LEVEL         8'hCA
`define EGPIO_B0_PD            8'hCC
`define EGPIO_B0_PU            8'hCE
`define EGPIO_B1_OUT           8'hD0
`define EGPIO_B1_OEN           8'hD1
`define EGPIO_B1_LEVEL         8'hD2
`define EGPIO_B1_PD            8'hD3
`define EGPIO_B1_PU            8'hD4
`define EGPIO_B2_OUT           8'hD5

`define EGPIO_B0_OUT_RST       16'h0000
`define EGPIO_B0_OEN_RST       16'hFFFF
`define EGPIO_B0_PD_RST        16'h0000
`define EGPIO_B0_PU_RST        16'h0000
`define EGPIO_B1_OUT_RST       8'h00
`define EGPIO_B1_OEN_RST       8'hFF
`define EGPIO_B1_PD_RST        8'h00
`define EGPIO_B1_PU_RST        8'h00
`define EGPIO_B2_OUT_RST       16'h0000
`define EGPIO_LOCK16_RST       16'h0000
`define EGPIO_LOCK8_RST        8'h00

`endif

// >>> logic/egpio_pin_sync.v
// Purpose: Three-stage synchroniser with agreement filter for pad inputs.
// Assumes: Pads are asynchronous to clk_sys.
// Notes:   Level updates only when stages two and three agree.
`timescale 1ns/100ps
module egpio_pin_sync #(
   parameter WIDTH = 16
) (
   input  wire             clk_sys,
   input  wire             rst,
   input  wire [WIDTH-1:0] pad_in,
   output reg  [WIDTH-1:0] level
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   genvar i;

   always @(posedge clk_sys) begin
      if (rst) begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
         stage3 <= {WIDTH{1'b0}};
      end else begin
         stage1 <= pad_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Stage one feeds only stage two; the filter looks at two and three
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clk_sys) begin
            if (rst) begin
               level[i] <= 1'b0;
            end else if (stage2[i] == stage3[i]) begin
               level[i] <= stage3[i];
            end
         end
      end
   endgenerate
endmodule

// >>> logic/egpio_lock_reg.v
// Purpose: Control register whose bits can be shielded by a lock mask.
// Assumes: Lock mask and write strobe come from the same clock.
// Notes:   Locked bits keep their value only when apply_lock is high.
`timescale 1ns/100ps
module egpio_lock_reg #(
   parameter             WIDTH = 16,
   parameter [WIDTH-1:0] RESET = {WIDTH{1'b0}}
) (
   input  wire             clk_sys,
   input  wire             rst,
   input  wire             wr_en,
   input  wire [WIDTH-1:0] wr_data,
   input  wire [WIDTH-1:0] lock_mask,
   input  wire             apply_lock,
   output reg  [WIDTH-1:0] value
);
   wire [WIDTH-1:0] keep;
   wire [WIDTH-1:0] next_value;

   assign keep       = apply_lock ? lock_mask : {WIDTH{1'b0}};
   assign next_value = (value & keep) | (wr_data & ~keep);

   always @(posedge clk_sys) begin
      if (rst) begin
         value <= RESET;
      end else if (wr_en) begin
         value <= next_value;
      end
   end
endmodule

// >>> logic/egpio_top.v
// Purpose: Register-controlled pin banks of the embedded controller.
// Assumes: One-cycle read and write strobes; read data one cycle later.
// Notes:   bus_is_controller high marks an access by the embedded controller,
//          low an access by host firmware, which the lock bits constrain.
// Operation
// - Bank 0 enable bit low drives pin, high tristates; resets to all ones.
// - Lock bits at A0h block firmware writes to bank 0 enable bits.
// - Bank 0 status read returns sampled level of each pin, read-only.
// - Pull-down bit 1 enables pull-down in banks 0 and 1; resets to zero.
// - Pull-up bit 0 enables pull-up in banks 0 and 1; resets to zero.
// - Bank 1 output bit n sets pin 18+n value; resets to 00h.
// - Bank 1 enable bit low drives pin 18+n, high tristates; resets FFh.
// - Lock bits at 98h block firmware writes to bank 1 output and enable.
// - Bank 1 status read returns input levels of pins 18 to 25.
// - Bank 2 output bit n sets pin 26+n low or high; resets 0000h.
// - Lock bits at 90h block firmware writes to bank 2 output bits.
// - Bank 0 output bit n sets pin n level; resets 0000h; A0h locks it.
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`include "egpio_defines.vh"
module egpio_top (
   input  wire                   clk_sys,
   input  wire                   rst,
   input  wire [`EGPIO_AW-1:0]   bus_addr,
   input  wire [`EGPIO_DW-1:0]   bus_wdata,
   input  wire                   bus_wr,
   input  wire                   bus_rd,
   input  wire                   bus_is_controller,
   output reg  [`EGPIO_DW-1:0]   bus_rdata,
   input  wire [`EGPIO_B0_W-1:0] bank0_pin_in,
   output wire [`EGPIO_B0_W-1:0] bank0_pin_out,
   output wire [`EGPIO_B0_W-1:0] bank0_pin_oe_n,
   output wire [`EGPIO_B0_W-1:0] bank0_pulldown_bits,
   output wire [`EGPIO_B0_W-1:0] bank0_pullup_off_bits,
   input  wire [`EGPIO_B1_W-1:0] bank1_pin_in,
   output wire [`EGPIO_B1_W-1:0] bank1_pin_out,
   output wire [`EGPIO_B1_W-1:0] bank1_pin_oe_n,
   output wire [`EGPIO_B1_W-1:0] bank1_pulldown_bits,
   output wire [`EGPIO_B1_W-1:0] bank1_pullup_off_bits,
   output wire [`EGPIO_B2_W-1:0] bank2_output_bits
);
   wire [`EGPIO_B0_W-1:0] bank0_output_bits;
   wire [`EGPIO_B0_W-1:0] bank0_drive_enable_n;
   wire [`EGPIO_B0_W-1:0] bank0_pin_levels;
   wire [`EGPIO_B1_W-1:0] bank1_output_bits;
   wire [`EGPIO_B1_W-1:0] bank1_drive_enable_n;
   wire [`EGPIO_B1_W-1:0] bank1_pin_levels;
   wire [`EGPIO_B0_W-1:0] lock_bank0;
   wire [`EGPIO_B1_W-1:0] lock_bank1;
   wire [`EGPIO_B2_W-1:0] lock_bank2;
   wire                   from_firmware;
   wire                   lock_wr_ok;
   reg  [`EGPIO_DW-1:0]   next_rdata;

   // Write hit on one register offset
   function wr_hit;
      input                 wr;
      input [`EGPIO_AW-1:0] addr;
      input [`EGPIO_AW-1:0] target;
      begin
         wr_hit = wr & (addr == target);
      end
   endfunction

   assign from_firmware = ~bus_is_controller;
   // Firmware must not be able to loosen its own locks
   assign lock_wr_ok    = bus_wr & bus_is_controller;

   // Lock registers
   egpio_lock_reg #(
      .WIDTH      (`EGPIO_B0_W),
      .RESET      (`EGPIO_LOCK16_RST)
   ) u_lock_b0 (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .wr_en      (wr_hit(lock_wr_ok, bus_addr, `EGPIO_LOCK_B0)),
      .wr_data    (bus_wdata),
      .lock_mask  ({`EGPIO_B0_W{1'b0}}),
      .apply_lock (1'b0),
      .value      (lock_bank0)
   );

   egpio_lock_reg #(
      .WIDTH      (`EGPIO_B1_W),
      .RESET      (`EGPIO_LOCK8_RST)
   ) u_lock_b1 (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .wr_en      (wr_hit(lock_wr_ok, bus_addr, `EGPIO_LOCK_B1)),
      .wr_data    (bus_wdata[`EGPIO_B1_W-1:0]),
      .lock_mask  ({`EGPIO_B1_W{1'b0}}),
      .apply_lock (1'b0),
      .value      (lock_bank1)
   );

   egpio_lock_reg #(
      .WIDTH      (`EGPIO_B2_W),
      .RESET      (`EGPIO_LOCK16_RST)
   ) u_lock_b2 (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .wr_en      (wr_hit(lock_wr_ok, bus_addr, `EGPIO_LOCK_B2)),
      .wr_data    (bus_wdata),
      .lock_mask  ({`EGPIO_B2_W{1'b0}}),
      .apply_lock (1'b0),
      .value      (lock_bank2)
   );

   // Bank 0 output value, lockable
   egpio_lock_reg #(
      .WIDTH      (`EGPIO_B0_W),
      .RESET      (`EGPIO_B0_OUT_RST)
   ) u_b0_out (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .wr_en      (wr_hit(bus_wr, bus_addr, `EGPIO_B0_OUT)),
      .wr_data    (bus_wdata),
      .lock_mask  (lock_bank0),
      .apply_lock (from_firmware),
      .value      (bank0_output_bits)
   );

   // Bank 0 drive enable, active low, lockable
   egpio_lock_reg #(
      .WIDTH      (`EGPIO_B0_W),
      .RESET      (`EGPIO_B0_OEN_RST)
   ) u_b0_oen (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .wr_en      (wr_hit(bus_wr, bus_addr, `EGPIO_B0_OEN)),
      .wr_data    (bus_wdata),
      .lock_mask  (lock_bank0),
      .apply_lock (from_firmware),
      .value      (bank0_drive_enable_n)
   );

   egpio_lock_reg #(
      .WIDTH      (`EGPIO_B0_W),
      .RESET      (`EGPIO_B0_PD_RST)
   ) u_b0_pd (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .wr_en      (wr_hit(bus_wr, bus_addr, `EGPIO_B0_PD)),
      .wr_data    (bus_wdata),
      .lock_mask  ({`EGPIO_B0_W{1'b0}}),
      .apply_lock (1'b0),
      .value      (bank0_pulldown_bits)
   );

   egpio_lock_reg #(
      .WIDTH      (`EGPIO_B0_W),
      .RESET      (`EGPIO_B0_PU_RST)
   ) u_b0_pu (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .wr_en      (wr_hit(bus_wr, bus_addr, `EGPIO_B0_PU)),
      .wr_data    (bus_wdata),
      .lock_mask  ({`EGPIO_B0_W{1'b0}}),
      .apply_lock (1'b0),
      .value      (bank0_pullup_off_bits)
   );

   // Bank 1: output taken as a pin level, not a second enable
   egpio_lock_reg #(
      .WIDTH      (`EGPIO_B1_W),
      .RESET      (`EGPIO_B1_OUT_RST)
   ) u_b1_out (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .wr_en      (wr_hit(bus_wr, bus_addr, `EGPIO_B1_OUT)),
      .wr_data    (bus_wdata[`EGPIO_B1_W-1:0]),
      .lock_mask  (lock_bank1),
      .apply_lock (from_firmware),
      .value      (bank1_output_bits)
   );

   egpio_lock_reg #(
      .WIDTH      (`EGPIO_B1_W),
      .RESET      (`EGPIO_B1_OEN_RST)
   ) u_b1_oen (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .wr_en      (wr_hit(bus_wr, bus_addr, `EGPIO_B1_OEN)),
      .wr_data    (bus_wdata[`EGPIO_B1_W-1:0]),
      .lock_mask  (lock_bank1),
      .apply_lock (from_firmware),
      .value      (bank1_drive_enable_n)
   );

   egpio_lock_reg #(
      .WIDTH      (`EGPIO_B1_W),
      .RESET      (`EGPIO_B1_PD_RST)
   ) u_b1_pd (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .wr_en      (wr_hit(bus_wr, bus_addr, `EGPIO_B1_PD)),
      .wr_data    (bus_wdata[`EGPIO_B1_W-1:0]),
      .lock_mask  ({`EGPIO_B1_W{1'b0}}),
      .apply_lock (1'b0),
      .value      (bank1_pulldown_bits)
   );

   egpio_lock_reg #(
      .WIDTH      (`EGPIO_B1_W),
      .RESET      (`EGPIO_B1_PU_RST)
   ) u_b1_pu (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .wr_en      (wr_hit(bus_wr, bus_addr, `EGPIO_B1_PU)),
      .wr_data    (bus_wdata[`EGPIO_B1_W-1:0]),
      .lock_mask  ({`EGPIO_B1_W{1'b0}}),
      .apply_lock (1'b0),
      .value      (bank1_pullup_off_bits)
   );

   // Bank 2 output value; its enable lives outside this block
   egpio_lock_reg #(
      .WIDTH      (`EGPIO_B2_W),
      .RESET      (`EGPIO_B2_OUT_RST)
   ) u_b2_out (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .wr_en      (wr_hit(bus_wr, bus_addr, `EGPIO_B2_OUT)),
      .wr_data    (bus_wdata),
      .lock_mask  (lock_bank2),
      .apply_lock (from_firmware),
      .value      (bank2_output_bits)
   );

   // Input levels are taken from the pad, so a driven pin reads back itself
   egpio_pin_sync #(
      .WIDTH   (`EGPIO_B0_W)
   ) u_b0_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pad_in  (bank0_pin_in),
      .level   (bank0_pin_levels)
   );

   egpio_pin_sync #(
      .WIDTH   (`EGPIO_B1_W)
   ) u_b1_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pad_in  (bank1_pin_in),
      .level   (bank1_pin_levels)
   );

   // Pad drivers: enable_n goes straight to the pad, value is always present
   assign bank0_pin_out  = bank0_output_bits;
   assign bank0_pin_oe_n = bank0_drive_enable_n;
   assign bank1_pin_out  = bank1_output_bits;
   assign bank1_pin_oe_n = bank1_drive_enable_n;

   // Read mux; unmapped offsets and narrow upper bits read as zero
   always @* begin
      next_rdata = {`EGPIO_DW{1'b0}};
      case (bus_addr)
         `EGPIO_LOCK_B0: begin
            next_rdata = lock_bank0;
         end
         `EGPIO_LOCK_B1: begin
            next_rdata[`EGPIO_B1_W-1:0] = lock_bank1;
         end
         `EGPIO_LOCK_B2: begin
            next_rdata = lock_bank2;
         end
         `EGPIO_B0_OUT: begin
            next_rdata = bank0_output_bits;
         end
         `EGPIO_B0_OEN: begin
            next_rdata = bank0_drive_enable_n;
         end
         `EGPIO_B0_LEVEL: begin
            next_rdata = bank0_pin_levels;
         end
         `EGPIO_B0_PD: begin
            next_rdata = bank0_pulldown_bits;
         end
         `EGPIO_B0_PU: begin
            next_rdata = bank0_pullup_off_bits;
         end
         `EGPIO_B1_OUT: begin
            next_rdata[`EGPIO_B1_W-1:0] = bank1_output_bits;
         end
         `EGPIO_B1_OEN: begin
            next_rdata[`EGPIO_B1_W-1:0] = bank1_drive_enable_n;
         end
         `EGPIO_B1_LEVEL: begin
            next_rdata[`EGPIO_B1_W-1:0] = bank1_pin_levels;
         end
         `EGPIO_B1_PD: begin
            next_rdata[`EGPIO_B1_W-1:0] = bank1_pulldown_bits;
         end
         `EGPIO_B1_PU: begin
            next_rdata[`EGPIO_B1_W-1:0] = bank1_pullup_off_bits;
         end
         `EGPIO_B2_OUT: begin
            next_rdata = bank2_output_bits;
         end
         default: begin
            next_rdata = {`EGPIO_DW{1'b0}};
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clk_sys) begin
      if (rst) begin
         bus_rdata <= {`EGPIO_DW{1'b0}};
      end else if (bus_rd) begin
         bus_rdata <= next_rdata;
      end else begin
         bus_rdata <= {`EGPIO_DW{1'b0}};
      end
   end
endmodule

// >>> bench/egpio_top_checker.sv
// Purpose: Concurrent checks on the register and pin-control ports of egpio_top.
// Assumes: Single clock domain; synchronous active-high reset.
// Notes:   Lock contents are not visible here, so only controller writes are exact.
`timescale 1ns/100ps
module egpio_top_checker (
   input wire        clk_sys,
   input wire        rst,
   input wire [7:0]  bus_addr,
   input wire [15:0] bus_wdata,
   input wire        bus_wr,
   input wire        bus_rd,
   input wire        bus_is_controller,
   input wire [15:0] bus_rdata,
   input wire [15:0] bank0_pin_oe_n,
   input wire [15:0] bank0_pulldown_bits,
   input wire [7:0]  bank1_pin_out,
   input wire [7:0]  bank1_pin_oe_n,
   input wire [7:0]  bank1_pullup_off_bits,
   input wire [15:0] bank2_output_bits
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire ctl_wr = bus_wr && bus_is_controller;

   chk_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
      else $error("read data not zero outside read cycle");
   chk_oen_reset: assert property ($past(rst) |-> bank0_pin_oe_n == 16'hFFFF)
      else $error("bank0 enable not all ones after reset");
   chk_b1_reset: assert property ($past(rst) |->
      bank1_pin_oe_n == 8'hFF && bank1_pin_out == 8'h00)
      else $error("bank1 output or enable reset value wrong");
   chk_oen_write: assert property (ctl_wr && bus_addr == 8'hC8 |=>
      bank0_pin_oe_n == $past(bus_wdata))
      else $error("bank0 enable did not take written value");
   chk_oen_hold: assert property (!$past(bus_wr) && !$past(rst) |->
      $stable(bank0_pin_oe_n))
      else $error("bank0 enable changed without a write");
   chk_b2_write: assert property (ctl_wr && bus_addr == 8'hD5 |=>
      bank2_output_bits == $past(bus_wdata))
      else $error("bank2 output did not take written value");
   chk_b2_read: assert property (bus_rd && bus_addr == 8'hD5 |=>
      bus_rdata == $past(bank2_output_bits))
      else $error("bank2 readback differs from output");
   chk_pd_write: assert property (ctl_wr && bus_addr == 8'hCC |=>
      bank0_pulldown_bits == $past(bus_wdata))
      else $error("bank0 pull-down did not take written value");
   chk_pu_write: assert property (ctl_wr && bus_addr == 8'hD4 |=>
      bank1_pullup_off_bits == $past(bus_wdata[7:0]))
      else $error("bank1 pull-up did not take written value");
   chk_b1out_write: assert property (ctl_wr && bus_addr == 8'hD0 |=>
      bank1_pin_out == $past(bus_wdata[7:0]))
      else $error("bank1 output did not take written value");
endmodule

bind egpio_top egpio_top_checker u_egpio_top_checker (
   .clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_is_controller(bus_is_controller),
   .bus_rdata(bus_rdata), .bank0_pin_oe_n(bank0_pin_oe_n),
   .bank0_pulldown_bits(bank0_pulldown_bits), .bank1_pin_out(bank1_pin_out),
   .bank1_pin_oe_n(bank1_pin_oe_n), .bank1_pullup_off_bits(bank1_pullup_off_bits),
   .bank2_output_bits(bank2_output_bits));

// >>> bench/egpio_pad_model.sv
// Purpose: Pad and board model: resolves each pin from chip drive, board drive and pulls.
// Assumes: Board never drives a pin the chip is driving.
// Notes:   A pin with no driver and no pull toggles every cycle, never holding its last value.
`timescale 1ns/100ps
module egpio_pad_model #(
   parameter WIDTH = 16
) (
   input  wire             clk_sys,
   input  wire [WIDTH-1:0] pin_out,
   input  wire [WIDTH-1:0] pin_oe_n,
   input  wire [WIDTH-1:0] pulldown_bits,
   input  wire [WIDTH-1:0] pullup_off_bits,
   input  wire [WIDTH-1:0] ext_val,
   input  wire [WIDTH-1:0] ext_en,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] float_pat = '0;
   always @(posedge clk_sys) begin
      float_pat <= ~float_pat;
   end
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         if (!pin_oe_n[i]) level[i] = pin_out[i];
         else if (ext_en[i]) level[i] = ext_val[i];
         else if (pulldown_bits[i]) level[i] = 1'b0;
         else if (!pullup_off_bits[i]) level[i] = 1'b1;
         else level[i] = float_pat[i];
      end
   end
endmodule

// >>> bench/embedded_mcu_gpio_banks_tb_top.sv
// Purpose: Self-checking bench for egpio_top with pad models on both input banks.
// Assumes: Register bus driven by non-blocking assignment after rising edges.
// Notes:   Pad changes are given six cycles to pass the input synchroniser.
`timescale 1ns/100ps
module embedded_mcu_gpio_banks_tb_top;
   typedef struct {logic [7:0] a; logic [15:0] r, w, e;} egpio_row_t;
   logic clk_sys = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, bus_is_controller = 1'b1;
   logic [7:0] bus_addr = 8'h00, b1_out, b1_oen, b1_pd, b1_pu, b1_in;
   logic [7:0] b1_ext_val = 8'h00, b1_ext_en = 8'h00;
   logic [15:0] bus_wdata = 16'h0000, bus_rdata, b0_out, b0_oen, b0_pd, b0_pu, b0_in, b2_out;
   logic [15:0] b0_ext_val = 16'h0000, b0_ext_en = 16'h0000;
   int mismatches = 0, n_tests = 0;
   egpio_row_t rows [13] = '{
      '{8'hC6, 16'h0000, 16'hA5A5, 16'hA5A5}, '{8'hC8, 16'hFFFF, 16'h00FE, 16'h00FE},
      '{8'hCC, 16'h0000, 16'h1234, 16'h1234}, '{8'hCE, 16'h0000, 16'h8001, 16'h8001},
      '{8'hD0, 16'h0000, 16'h5A5A, 16'h005A}, '{8'hD1, 16'h00FF, 16'h1234, 16'h0034},
      '{8'hD3, 16'h0000, 16'h00C3, 16'h00C3}, '{8'hD4, 16'h0000, 16'hFF3C, 16'h003C},
      '{8'hD5, 16'h0000, 16'hBEEF, 16'hBEEF}, '{8'hA0, 16'h0000, 16'h1234, 16'h1234},
      '{8'h98, 16'h0000, 16'hFFA5, 16'h00A5}, '{8'h90, 16'h0000, 16'h5678, 16'h5678},
      '{8'h10, 16'h0000, 16'hFFFF, 16'h0000}};

   always #2.5 clk_sys = ~clk_sys;

   egpio_top u_egpio_top (
      .clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_is_controller(bus_is_controller),
      .bus_rdata(bus_rdata), .bank0_pin_in(b0_in), .bank0_pin_out(b0_out),
      .bank0_pin_oe_n(b0_oen), .bank0_pulldown_bits(b0_pd), .bank0_pullup_off_bits(b0_pu),
      .bank1_pin_in(b1_in), .bank1_pin_out(b1_out), .bank1_pin_oe_n(b1_oen),
      .bank1_pulldown_bits(b1_pd), .bank1_pullup_off_bits(b1_pu),
      .bank2_output_bits(b2_out));
   egpio_pad_model #(.WIDTH(16)) u_egpio_pad_model_b0 (
      .clk_sys(clk_sys), .pin_out(b0_out), .pin_oe_n(b0_oen), .pulldown_bits(b0_pd),
      .pullup_off_bits(b0_pu), .ext_val(b0_ext_val), .ext_en(b0_ext_en), .level(b0_in));
   egpio_pad_model #(.WIDTH(8)) u_egpio_pad_model_b1 (
      .clk_sys(clk_sys), .pin_out(b1_out), .pin_oe_n(b1_oen), .pulldown_bits(b1_pd),
      .pullup_off_bits(b1_pu), .ext_val(b1_ext_val), .ext_en(b1_ext_en), .level(b1_in));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic ctl, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      bus_is_controller <= ctl;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      bus_rd <= 1'b1;
      bus_addr <= a;
      bus_is_controller <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1 check(bus_rdata, exp);
   endtask
   task automatic settle;
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic print_verdict;
      if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge clk_sys);
      mismatches++;
      print_verdict;
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      foreach (rows[i]) begin
         rd(rows[i].a, rows[i].r);
         wr(1'b1, rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].e);
      end
      // Host writes: locked bits hold, unlocked bits follow
      wr(1'b1, 8'hC8, 16'hFFFF);
      wr(1'b1, 8'hA0, 16'h00FF);
      wr(1'b0, 8'hC8, 16'h0000);
      check(b0_oen, 16'h00FF);
      wr(1'b0, 8'hC6, 16'hFFFF);
      check(b0_out, 16'hFFA5);
      wr(1'b0, 8'hA0, 16'h0000);
      rd(8'hA0, 16'h00FF);
      wr(1'b1, 8'h98, 16'h000F);
      wr(1'b0, 8'hD0, 16'h00FF);
      wr(1'b0, 8'hD1, 16'h0000);
      check({8'h00, b1_out}, 16'h00FA);
      check({8'h00, b1_oen}, 16'h0004);
      wr(1'b1, 8'h90, 16'hFF00);
      wr(1'b0, 8'hD5, 16'h0000);
      check(b2_out, 16'hBE00);
      // Pin levels: board drive, chip drive, then pulls only
      wr(1'b1, 8'hC8, 16'hFFFF);
      b0_ext_en <= 16'hFFFF;
      b0_ext_val <= 16'h3C5A;
      settle;
      rd(8'hCA, 16'h3C5A);
      b0_ext_en <= 16'h0000;
      wr(1'b1, 8'hC6, 16'hA55A);
      wr(1'b1, 8'hC8, 16'h0000);
      settle;
      rd(8'hCA, 16'hA55A);
      wr(1'b1, 8'hC8, 16'hFFFF);
      wr(1'b1, 8'hCC, 16'h00FF);
      wr(1'b1, 8'hCE, 16'h00FF);
      settle;
      rd(8'hCA, 16'hFF00);
      wr(1'b1, 8'hD1, 16'h00FF);
      b1_ext_en <= 8'hFF;
      b1_ext_val <= 8'hC3;
      settle;
      rd(8'hD2, 16'h00C3);
      b1_ext_en <= 8'h00;
      wr(1'b1, 8'hD3, 16'h000F);
      wr(1'b1, 8'hD4, 16'h000F);
      settle;
      rd(8'hD2, 16'h00F0);
      wr(1'b1, 8'hD0, 16'h0066);
      wr(1'b1, 8'hD1, 16'h0000);
      settle;
      rd(8'hD2, 16'h0066);
      // Reset in mid-run restores defaults and clears locks
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(8'hC8, 16'hFFFF);
      rd(8'hD1, 16'h00FF);
      rd(8'hD5, 16'h0000);
      rd(8'h90, 16'h0000);
      print_verdict;
   end
endmodule
